// ---- common/scp_pkg.sv ----
// constants shared by both ends of the serial control port
// What this block does
// - update strobe rising edge copies buffers to active
// - host holds chip select low while programming
// - device responds only while its select is low
// - 3-wire reads come out on serial_read_out
// - 3-wire writes enter on data pin, input only
// - 2-wire reads and writes share the data pin
// - host supplies serial clock for every bit
// - power-down input makes device inactive while high
// - chip reset input holds device in reset
// - internal 10 us reset at power-up
package scp_pkg;
  // ----------------------------------------------------------------
  // frame layout: {rw, addr[6:0]} then data[7:0], msb first
  // ----------------------------------------------------------------
  localparam int DATA_W      = 8;
  localparam int ADDR_W      = 7;
  localparam int FRAME_BITS  = 16;
  localparam int CNT_W       = 5;
  localparam int NUM_REGS    = 4;
  localparam int REG_IDX_W   = 2;
  localparam logic [CNT_W-1:0] CNT_RW_BIT    = 5'h00;
  localparam logic [CNT_W-1:0] CNT_ADDR_LAST = 5'h07;
  localparam logic [CNT_W-1:0] CNT_DATA_FST  = 5'h08;
  localparam logic [CNT_W-1:0] CNT_LAST      = 5'h0F;
  localparam logic [CNT_W-1:0] CNT_DONE      = 5'h10;
  localparam logic             RW_READ       = 1'b1;
  // ----------------------------------------------------------------
  // register reset values and mode field
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0]    CTRL_RESET   = 8'h00;
  localparam logic [REG_IDX_W-1:0] MODE_REG_IDX = 2'h0;
  localparam int                   MODE_BIT_POS = 0;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 10;
  localparam int POR_TIME_US    = 10;
  localparam int POR_CYCLES     = (POR_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POR_CNT_W      = 10;
  localparam int SCLK_PERIOD_NS = 80;
  localparam int SCLK_HALF_CYC  = SCLK_PERIOD_NS / 2 / CLK_PERIOD_NS;
  localparam int DIV_W          = 3;
  localparam int UPD_HIGH_CYC   = 4;
endpackage

// ---- common/scp_if.sv ----
// pins between the host controller and the programming port
`timescale 1ns/1ns
interface scp_if;
  logic sclk;
  logic chip_select_n;
  logic io_update;
  logic chip_reset;
  logic power_down_in;
  logic sdio_host_o;
  logic sdio_host_oe;
  logic sdio_dev_o;
  logic sdio_dev_oe;
  logic serial_read_out;
  logic serial_read_out_oe;
  logic sdio;
  logic serial_read_out_line;

  // ----------------------------------------------------------------
  // wire resolution, undriven lines read high
  // ----------------------------------------------------------------
  assign sdio = sdio_dev_oe ? sdio_dev_o : (sdio_host_oe ? sdio_host_o : 1'b1);
  assign serial_read_out_line = serial_read_out_oe ? serial_read_out : 1'b1;

  modport dev (
    input  sclk, chip_select_n, io_update, chip_reset, power_down_in, sdio,
    output sdio_dev_o, sdio_dev_oe, serial_read_out, serial_read_out_oe
  );
  modport host (
    input  sdio, serial_read_out_line,
    output sclk, chip_select_n, io_update, chip_reset, power_down_in, sdio_host_o, sdio_host_oe
  );
endinterface

// ---- rtl/scp_device.sv ----
// serial programming port of the device: link shifter and control registers
`timescale 1ns/1ns
module scp_device (
  input  wire logic                                  i_clk,
  input  wire logic                                  i_rst_n,
  scp_if.dev                                         bus,
  output logic [scp_pkg::NUM_REGS*scp_pkg::DATA_W-1:0] o_ctrl,
  output logic                                       o_powered_down,
  output logic                                       o_in_reset
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [scp_pkg::CNT_W-1:0]  cnt_q,    cnt_d;
  logic [scp_pkg::DATA_W-1:0] sh_q,     sh_d;
  logic                       rd_q,     rd_d;
  logic [scp_pkg::ADDR_W-1:0] addr_q,   addr_d;
  logic [scp_pkg::ADDR_W-1:0] wr_addr_q, wr_addr_d;
  logic [scp_pkg::DATA_W-1:0] wr_data_q, wr_data_d;
  logic                       wr_tgl_q, wr_tgl_d;
  logic [1:0]                 rdy_ls_q;
  logic [1:0]                 mode_ls_q;
  logic                       so_bit_q, so_bit_d;
  logic                       so_oe_q,  so_oe_d;
  logic                       sd_oe_q,  sd_oe_d;
  logic [scp_pkg::DATA_W-1:0] rd_word;
  logic [2:0]                 bit_idx;
  logic                       drive;

  logic [2:0]                 upd_s_q,  upd_s_d;
  logic [1:0]                 crst_s_q, crst_s_d;
  logic [1:0]                 pdn_s_q,  pdn_s_d;
  logic [2:0]                 wt_s_q,   wt_s_d;
  logic [scp_pkg::POR_CNT_W-1:0] por_q, por_d;
  logic                       rst_q,    rst_d;
  logic                       pdn_q,    pdn_d;
  logic                       rdy_q,    rdy_d;
  logic [scp_pkg::DATA_W-1:0] buf_q [scp_pkg::NUM_REGS];
  logic [scp_pkg::DATA_W-1:0] buf_d [scp_pkg::NUM_REGS];
  logic [scp_pkg::DATA_W-1:0] act_q [scp_pkg::NUM_REGS];
  logic [scp_pkg::DATA_W-1:0] act_d [scp_pkg::NUM_REGS];
  logic                       in_reset;
  logic                       wr_evt;
  logic                       upd_evt;

  // ----------------------------------------------------------------
  // link side: input shifter on rising serial clock
  // ----------------------------------------------------------------
  always_comb begin
    cnt_d     = cnt_q;
    sh_d      = {sh_q[scp_pkg::DATA_W-2:0], bus.sdio};
    rd_d      = rd_q;
    addr_d    = addr_q;
    wr_addr_d = wr_addr_q;
    wr_data_d = wr_data_q;
    wr_tgl_d  = wr_tgl_q;
    if (cnt_q != scp_pkg::CNT_DONE) begin
      cnt_d = cnt_q + 5'h01;
    end
    if (cnt_q == scp_pkg::CNT_RW_BIT) begin
      rd_d = bus.sdio;
    end
    if (cnt_q == scp_pkg::CNT_ADDR_LAST) begin
      addr_d = {sh_q[scp_pkg::ADDR_W-2:0], bus.sdio};
    end
    // write commits only on the last bit of a complete frame
    if (cnt_q == scp_pkg::CNT_LAST && rd_q != scp_pkg::RW_READ && rdy_ls_q[1]) begin
      wr_addr_d = addr_q;
      wr_data_d = {sh_q[scp_pkg::DATA_W-2:0], bus.sdio};
      wr_tgl_d  = ~wr_tgl_q;
    end
  end

  // select high clears the frame state at once, partial frames are lost
  always_ff @(posedge bus.sclk or posedge bus.chip_select_n) begin
    if (bus.chip_select_n) begin
      cnt_q  <= '0;
      sh_q   <= '0;
      rd_q   <= 1'b0;
      addr_q <= '0;
    end else begin
      cnt_q  <= cnt_d;
      sh_q   <= sh_d;
      rd_q   <= rd_d;
      addr_q <= addr_d;
    end
  end

  // handoff word and level synchronisers, cleared only by power-on reset
  always_ff @(posedge bus.sclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_addr_q <= '0;
      wr_data_q <= '0;
      wr_tgl_q  <= 1'b0;
      rdy_ls_q  <= 2'h0;
      mode_ls_q <= 2'h0;
    end else begin
      wr_addr_q <= bus.chip_select_n ? wr_addr_q : wr_addr_d;
      wr_data_q <= bus.chip_select_n ? wr_data_q : wr_data_d;
      wr_tgl_q  <= bus.chip_select_n ? wr_tgl_q : wr_tgl_d;
      rdy_ls_q  <= {rdy_ls_q[0], rdy_q};
      mode_ls_q <= {mode_ls_q[0], act_q[scp_pkg::MODE_REG_IDX][scp_pkg::MODE_BIT_POS]};
    end
  end

  // ----------------------------------------------------------------
  // link side: read data launched on falling serial clock
  // ----------------------------------------------------------------
  // buffers only change after a completed write frame or in reset, so they are
  // static while a read frame shifts them out
  assign rd_word = (addr_q < scp_pkg::ADDR_W'(scp_pkg::NUM_REGS))
                   ? buf_q[addr_q[scp_pkg::REG_IDX_W-1:0]] : '0;
  assign bit_idx = 3'(scp_pkg::CNT_LAST - cnt_q);
  assign drive   = rd_q && rdy_ls_q[1] && (cnt_q >= scp_pkg::CNT_DATA_FST) && (cnt_q != scp_pkg::CNT_DONE);

  always_comb begin
    so_bit_d = rd_word[bit_idx];
    so_oe_d  = drive && mode_ls_q[1];
    sd_oe_d  = drive && !mode_ls_q[1];
  end

  always_ff @(negedge bus.sclk or posedge bus.chip_select_n) begin
    if (bus.chip_select_n) begin
      so_bit_q <= 1'b0;
      so_oe_q  <= 1'b0;
      sd_oe_q  <= 1'b0;
    end else begin
      so_bit_q <= so_bit_d;
      so_oe_q  <= so_oe_d;
      sd_oe_q  <= sd_oe_d;
    end
  end

  assign bus.serial_read_out    = so_bit_q;
  assign bus.serial_read_out_oe = so_oe_q;
  assign bus.sdio_dev_o         = so_bit_q;
  assign bus.sdio_dev_oe        = sd_oe_q;

  // ----------------------------------------------------------------
  // system side: pin synchronisers and reset control
  // ----------------------------------------------------------------
  always_comb begin
    upd_s_d  = {upd_s_q[1:0], bus.io_update};
    crst_s_d = {crst_s_q[0], bus.chip_reset};
    pdn_s_d  = {pdn_s_q[0], bus.power_down_in};
    wt_s_d   = {wt_s_q[1:0], wr_tgl_q};
    por_d    = por_q;
    if (por_q != scp_pkg::POR_CNT_W'(scp_pkg::POR_CYCLES)) begin
      por_d = por_q + 10'h001;
    end
    rst_d = crst_s_q[1] || (por_q != scp_pkg::POR_CNT_W'(scp_pkg::POR_CYCLES));
    pdn_d = pdn_s_q[1];
    rdy_d = !rst_q && !pdn_q;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      upd_s_q  <= 3'h0;
      crst_s_q <= 2'h0;
      pdn_s_q  <= 2'h0;
      wt_s_q   <= 3'h0;
      por_q    <= '0;
      rst_q    <= 1'b1;
      pdn_q    <= 1'b0;
      rdy_q    <= 1'b0;
    end else begin
      upd_s_q  <= upd_s_d;
      crst_s_q <= crst_s_d;
      pdn_s_q  <= pdn_s_d;
      wt_s_q   <= wt_s_d;
      por_q    <= por_d;
      rst_q    <= rst_d;
      pdn_q    <= pdn_d;
      rdy_q    <= rdy_d;
    end
  end

  // ----------------------------------------------------------------
  // system side: buffered and active control registers
  // ----------------------------------------------------------------
  assign in_reset = rst_q;
  assign wr_evt   = wt_s_q[2] != wt_s_q[1];
  assign upd_evt  = upd_s_q[1] && !upd_s_q[2];

  always_comb begin
    for (int i = 0; i < scp_pkg::NUM_REGS; i++) begin
      buf_d[i] = buf_q[i];
      act_d[i] = act_q[i];
    end
    if (in_reset) begin
      for (int i = 0; i < scp_pkg::NUM_REGS; i++) begin
        buf_d[i] = scp_pkg::CTRL_RESET;
        act_d[i] = scp_pkg::CTRL_RESET;
      end
    end else if (!pdn_q) begin
      if (upd_evt) begin
        for (int i = 0; i < scp_pkg::NUM_REGS; i++) begin
          act_d[i] = buf_q[i];
        end
      end
      if (wr_evt && wr_addr_q < scp_pkg::ADDR_W'(scp_pkg::NUM_REGS)) begin
        buf_d[wr_addr_q[scp_pkg::REG_IDX_W-1:0]] = wr_data_q;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      for (int i = 0; i < scp_pkg::NUM_REGS; i++) begin
        buf_q[i] <= scp_pkg::CTRL_RESET;
        act_q[i] <= scp_pkg::CTRL_RESET;
      end
    end else begin
      for (int i = 0; i < scp_pkg::NUM_REGS; i++) begin
        buf_q[i] <= buf_d[i];
        act_q[i] <= act_d[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // user side outputs
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < scp_pkg::NUM_REGS; i++) begin
      o_ctrl[i*scp_pkg::DATA_W +: scp_pkg::DATA_W] = act_q[i];
    end
  end

  assign o_powered_down = pdn_q;
  assign o_in_reset     = rst_q;
endmodule

// ---- rtl/scp_host.sv ----
// host controller end: frames serial writes and reads, drives strobes
`timescale 1ns/1ns
module scp_host (
  input  wire logic                       i_clk,
  input  wire logic                       i_rst_n,
  input  wire logic                       i_start,
  input  wire logic                       i_rw,
  input  wire logic [scp_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [scp_pkg::DATA_W-1:0] i_wdata,
  input  wire logic                       i_three_wire,
  input  wire logic                       i_update,
  input  wire logic                       i_chip_reset,
  input  wire logic                       i_power_down,
  output logic                            o_busy,
  output logic                            o_done,
  output logic [scp_pkg::DATA_W-1:0]      o_rdata,
  scp_if.host                             bus
);
  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_UPD} scp_state_e;

  scp_state_e                      st_q,    st_d;
  logic [scp_pkg::DIV_W-1:0]       div_q,   div_d;
  logic [scp_pkg::CNT_W-1:0]       bit_q,   bit_d;
  logic [scp_pkg::FRAME_BITS-1:0]  frm_q,   frm_d;
  logic                            rd_q,    rd_d;
  logic                            mode_q,  mode_d;
  logic [scp_pkg::DATA_W-1:0]      rdat_q,  rdat_d;
  logic                            sclk_q,  sclk_d;
  logic                            csn_q,   csn_d;
  logic                            oe_q,    oe_d;
  logic                            done_q,  done_d;
  logic                            upd_q,   upd_d;
  logic [scp_pkg::DIV_W-1:0]       ucnt_q,  ucnt_d;
  logic                            crst_q;
  logic                            pdn_q;
  logic [1:0]                      sdio_s_q;
  logic [1:0]                      rdo_s_q;
  logic                            rx_bit;

  assign rx_bit = mode_q ? rdo_s_q[1] : sdio_s_q[1];

  // ----------------------------------------------------------------
  // frame sequencer, serial clock from divider
  // ----------------------------------------------------------------
  always_comb begin
    st_d   = st_q;
    div_d  = div_q;
    bit_d  = bit_q;
    frm_d  = frm_q;
    rd_d   = rd_q;
    mode_d = mode_q;
    rdat_d = rdat_q;
    sclk_d = sclk_q;
    csn_d  = csn_q;
    oe_d   = oe_q;
    done_d = 1'b0;
    upd_d  = upd_q;
    ucnt_d = ucnt_q;
    unique case (st_q)
      ST_IDLE: begin
        if (i_start) begin
          st_d   = ST_SHIFT;
          frm_d  = {i_rw, i_addr, i_wdata};
          rd_d   = i_rw;
          mode_d = i_three_wire;
          div_d  = '0;
          bit_d  = '0;
          csn_d  = 1'b0;
          oe_d   = 1'b1;
        end else if (i_update) begin
          st_d   = ST_UPD;
          upd_d  = 1'b1;
          ucnt_d = '0;
        end
      end
      ST_SHIFT: begin
        div_d = div_q + 3'h1;
        if (div_q == scp_pkg::DIV_W'(scp_pkg::SCLK_HALF_CYC - 1)) begin
          div_d = '0;
          if (!sclk_q) begin
            sclk_d = 1'b1;
            if (rd_q && bit_q >= scp_pkg::CNT_DATA_FST) begin
              rdat_d = {rdat_q[scp_pkg::DATA_W-2:0], rx_bit};
            end
          end else begin
            sclk_d = 1'b0;
            bit_d  = bit_q + 5'h01;
            frm_d  = {frm_q[scp_pkg::FRAME_BITS-2:0], 1'b0};
            if (bit_q == scp_pkg::CNT_LAST) begin
              st_d   = ST_IDLE;
              csn_d  = 1'b1;
              oe_d   = 1'b0;
              done_d = 1'b1;
            end else if (rd_q && bit_q == scp_pkg::CNT_ADDR_LAST) begin
              oe_d = 1'b0;
            end
          end
        end
      end
      ST_UPD: begin
        ucnt_d = ucnt_q + 3'h1;
        if (ucnt_q == scp_pkg::DIV_W'(scp_pkg::UPD_HIGH_CYC - 1)) begin
          st_d  = ST_IDLE;
          upd_d = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_q     <= ST_IDLE;
      div_q    <= '0;
      bit_q    <= '0;
      frm_q    <= '0;
      rd_q     <= 1'b0;
      mode_q   <= 1'b0;
      rdat_q   <= '0;
      sclk_q   <= 1'b0;
      csn_q    <= 1'b1;
      oe_q     <= 1'b0;
      done_q   <= 1'b0;
      upd_q    <= 1'b0;
      ucnt_q   <= '0;
      crst_q   <= 1'b0;
      pdn_q    <= 1'b0;
      sdio_s_q <= 2'h0;
      rdo_s_q  <= 2'h0;
    end else begin
      st_q     <= st_d;
      div_q    <= div_d;
      bit_q    <= bit_d;
      frm_q    <= frm_d;
      rd_q     <= rd_d;
      mode_q   <= mode_d;
      rdat_q   <= rdat_d;
      sclk_q   <= sclk_d;
      csn_q    <= csn_d;
      oe_q     <= oe_d;
      done_q   <= done_d;
      upd_q    <= upd_d;
      ucnt_q   <= ucnt_d;
      crst_q   <= i_chip_reset;
      pdn_q    <= i_power_down;
      sdio_s_q <= {sdio_s_q[0], bus.sdio};
      rdo_s_q  <= {rdo_s_q[0], bus.serial_read_out_line};
    end
  end

  // ----------------------------------------------------------------
  // pins and user outputs
  // ----------------------------------------------------------------
  assign bus.sclk          = sclk_q;
  assign bus.chip_select_n = csn_q;
  assign bus.sdio_host_o   = frm_q[scp_pkg::FRAME_BITS-1];
  assign bus.sdio_host_oe  = oe_q;
  assign bus.io_update     = upd_q;
  assign bus.chip_reset    = crst_q;
  assign bus.power_down_in = pdn_q;
  assign o_busy            = st_q != ST_IDLE;
  assign o_done            = done_q;
  assign o_rdata           = rdat_q;
endmodule

// ---- dv/scp_link_sva.sv ----
// link pin checks between the host end and the device end
`timescale 1ns/1ns
module scp_link_sva (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic sclk,
  input wire logic chip_select_n,
  input wire logic io_update,
  input wire logic chip_reset,
  input wire logic power_down_in,
  input wire logic sdio_host_oe,
  input wire logic sdio_dev_oe,
  input wire logic serial_read_out_oe
);
  // ----------------------------------------------------------------
  // frame shape and pin ownership
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_sel_frame;
    !chip_select_n throughout ##127 1'b1;
  endsequence
  sequence s_cmd_phase;
    (sdio_host_oe && !sdio_dev_oe && !serial_read_out_oe) throughout ##63 1'b1;
  endsequence
  sequence s_upd_high;
    io_update[*4] ##1 !io_update;
  endsequence

  AST_CS_HELD: assert property ($fell(chip_select_n) |-> s_sel_frame ##1 chip_select_n)
    else $error("chip select not held low for one whole frame");
  AST_CMD_PHASE: assert property ($fell(chip_select_n) |-> s_cmd_phase)
    else $error("command phase not driven by host alone");
  AST_SCLK_IN_FRAME: assert property (sclk |-> !chip_select_n)
    else $error("serial clock high outside a frame");
  AST_SCLK_HIGH: assert property ($rose(sclk) |-> sclk[*4] ##1 !sclk)
    else $error("serial clock high phase not four cycles");
  AST_ONE_DRIVER: assert property (!(sdio_dev_oe && sdio_host_oe))
    else $error("both ends drive the data line");
  AST_ONE_PIN: assert property (!(sdio_dev_oe && serial_read_out_oe))
    else $error("device drives both read pins");
  AST_IDLE_RELEASE: assert property (chip_select_n[*6] |-> !sdio_dev_oe && !serial_read_out_oe)
    else $error("device drives a pin while deselected");
  AST_PD_QUIET: assert property (power_down_in[*8] |-> !sdio_dev_oe && !serial_read_out_oe)
    else $error("device drives a pin in power-down");
  AST_RST_QUIET: assert property (chip_reset[*8] |-> !sdio_dev_oe && !serial_read_out_oe)
    else $error("device drives a pin in chip reset");
  AST_UPD_IDLE: assert property ($rose(io_update) |-> chip_select_n ##0 s_upd_high)
    else $error("update strobe malformed or inside a frame");
endmodule

// ---- dv/serial_control_port_pins_tb.sv ----
// self-checking bench: host and device joined, plus a hand-driven second device
`timescale 1ns/1ns
module serial_control_port_pins_tb;
  typedef struct packed {logic rd; logic [7:0] val;} scp_exp_s;
  logic        i_clk, i_rst_n, start, rw, tw, upd, crst, pdn, busy, done, pdq, inr, inr2;
  logic [6:0]  addr;
  logic [7:0]  wdata, rdata, seed, bm[4], am[4];
  logic [31:0] ctrl, ctrl2;
  int          n_fail = 0, checked = 0, cyc = 0;
  scp_exp_s    expq[$], e;

  scp_if u_scp_if ();
  scp_if u_scp_if_2 ();
  scp_host u_scp_host (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_start(start), .i_rw(rw), .i_addr(addr),
    .i_wdata(wdata), .i_three_wire(tw), .i_update(upd), .i_chip_reset(crst), .i_power_down(pdn),
    .o_busy(busy), .o_done(done), .o_rdata(rdata), .bus(u_scp_if.host));
  scp_device u_scp_device (.i_clk(i_clk), .i_rst_n(i_rst_n), .bus(u_scp_if.dev), .o_ctrl(ctrl),
    .o_powered_down(pdq), .o_in_reset(inr));
  scp_device u_scp_device_2 (.i_clk(i_clk), .i_rst_n(i_rst_n), .bus(u_scp_if_2.dev), .o_ctrl(ctrl2),
    .o_powered_down(), .o_in_reset(inr2));
  scp_link_sva u_scp_link_sva (.i_clk(i_clk), .i_rst_n(i_rst_n), .sclk(u_scp_if.sclk),
    .chip_select_n(u_scp_if.chip_select_n), .io_update(u_scp_if.io_update),
    .chip_reset(u_scp_if.chip_reset), .power_down_in(u_scp_if.power_down_in),
    .sdio_host_oe(u_scp_if.sdio_host_oe), .sdio_dev_oe(u_scp_if.sdio_dev_oe),
    .serial_read_out_oe(u_scp_if.serial_read_out_oe));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // one host frame; reads note the expected data for the monitor
  task automatic frame(input logic r, input logic [6:0] a, input logic [7:0] d);
    scp_exp_s x;
    logic     live;
    live = !pdn && !crst;
    if (live && !r && a < 7'h04) bm[a[1:0]] = d;
    x.rd = r;
    x.val = (!live || tw !== am[0][0]) ? 8'hFF : (a < 7'h04 ? bm[a[1:0]] : 8'h00);
    expq.push_back(x);
    start = 1'b1;
    rw = r;
    addr = a;
    wdata = d;
    tick(1);
    start = 1'b0;
    check("busy", {31'h0, busy}, 32'h1);
    for (int k = 0; k < 200 && done !== 1'b1; k++) tick(1);
    tick(1);
    check("busy", {31'h0, busy}, 32'h0);
  endtask
  task automatic update(input logic take);
    upd = 1'b1;
    tick(1);
    upd = 1'b0;
    tick(12);
    if (take) am = bm;
  endtask
  // hand-driven frame on the second device; sel low keeps it deselected
  task automatic bang(input logic [15:0] f, input int n, input logic sel);
    #3 u_scp_if_2.chip_select_n = ~sel;
    for (int i = 0; i < n; i++) begin
      u_scp_if_2.sdio_host_oe = (i < 8) || !f[15];
      u_scp_if_2.sdio_host_o = f[15-i];
      #40 u_scp_if_2.sclk = 1'b1;
      #40 u_scp_if_2.sclk = 1'b0;
    end
    #40 u_scp_if_2.sdio_host_oe = 1'b0;
    u_scp_if_2.chip_select_n = 1'b1;
    tick(8);
  endtask
  task automatic update2;
    u_scp_if_2.io_update = 1'b1;
    tick(4);
    u_scp_if_2.io_update = 1'b0;
    tick(12);
  endtask

  // ----------------------------------------------------------------
  // clock, monitor, timeout and sequence
  // ----------------------------------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  always @(negedge i_clk) begin
    cyc++;
    if (done === 1'b1 && expq.size() > 0) begin
      e = expq.pop_front();
      if (e.rd) check("rdata", {24'h0, rdata}, {24'h0, e.val});
    end
    if (cyc == 40000) begin
      n_fail++;
      give_verdict();
    end
  end
  initial begin
    {start, rw, tw, upd, crst, pdn, i_rst_n} = '0;
    addr = '0;
    wdata = '0;
    seed = 8'h3B;
    bm = '{default: 8'h00};
    am = '{default: 8'h00};
    {u_scp_if_2.sclk, u_scp_if_2.io_update, u_scp_if_2.chip_reset} = '0;
    {u_scp_if_2.power_down_in, u_scp_if_2.sdio_host_o, u_scp_if_2.sdio_host_oe} = '0;
    u_scp_if_2.chip_select_n = 1'b1;
    tick(3);
    check("ctrl", ctrl, 32'h0);
    check("in_reset", {31'h0, inr}, 32'h1);
    i_rst_n = 1'b1;
    tick(990);
    check("in_reset", {31'h0, inr}, 32'h1);
    tick(20);
    check("in_reset", {31'h0, inr}, 32'h0);
    check("in_reset2", {31'h0, inr2}, 32'h0);
    $display("test power-up reset done");
    for (int a = 0; a < 4; a++) begin
      seed = lfsr(seed);
      frame(1'b0, 7'(a), a == 0 ? seed & 8'hFE : seed);
    end
    frame(1'b0, 7'h7D, 8'hFF);
    check("ctrl", ctrl, 32'h0);
    for (int a = 0; a < 5; a++) frame(1'b1, a == 4 ? 7'h7F : 7'(a), 8'h00);
    update(1'b1);
    check("ctrl", ctrl, {am[3], am[2], am[1], am[0]});
    $display("test two-wire writes and reads done");
    seed = lfsr(seed);
    frame(1'b0, 7'h00, seed | 8'h01);
    update(1'b1);
    check("ctrl", ctrl, {am[3], am[2], am[1], am[0]});
    frame(1'b1, 7'h01, 8'h00);
    tw = 1'b1;
    for (int a = 1; a < 4; a++) begin
      seed = lfsr(seed);
      frame(1'b0, 7'(a), seed);
      frame(1'b1, 7'(a), 8'h00);
    end
    frame(1'b1, 7'h00, 8'h00);
    $display("test three-wire mode done");
    pdn = 1'b1;
    tick(10);
    check("powered_down", {31'h0, pdq}, 32'h1);
    frame(1'b0, 7'h01, ~bm[1]);
    frame(1'b1, 7'h01, 8'h00);
    update(1'b0);
    check("ctrl", ctrl, {am[3], am[2], am[1], am[0]});
    pdn = 1'b0;
    tick(10);
    check("powered_down", {31'h0, pdq}, 32'h0);
    frame(1'b1, 7'h01, 8'h00);
    $display("test power-down done");
    crst = 1'b1;
    tick(10);
    check("in_reset", {31'h0, inr}, 32'h1);
    check("ctrl", ctrl, 32'h0);
    bm = '{default: 8'h00};
    am = '{default: 8'h00};
    frame(1'b1, 7'h02, 8'h00);
    crst = 1'b0;
    tw = 1'b0;
    tick(10);
    check("in_reset", {31'h0, inr}, 32'h0);
    frame(1'b1, 7'h02, 8'h00);
    $display("test chip reset done");
    bang({1'b0, 7'h01, 8'hA5}, 16, 1'b1);
    update2();
    check("ctrl2", ctrl2, 32'h0000A500);
    bang({1'b0, 7'h01, 8'h3C}, 12, 1'b1);
    update2();
    check("ctrl2", ctrl2, 32'h0000A500);
    bang({1'b1, 7'h01, 8'h00}, 10, 1'b1);
    check("dev_oe2", {30'h0, u_scp_if_2.sdio_dev_oe, u_scp_if_2.serial_read_out_oe}, 32'h0);
    bang({1'b0, 7'h01, 8'h77}, 16, 1'b0);
    update2();
    check("ctrl2", ctrl2, 32'h0000A500);
    $display("test second device select and abort done");
    tick(4);
    give_verdict();
  end
endmodule
